// ### ddc_ctrl_pkg.sv
`default_nettype none

package ddc_ctrl_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;
	localparam int WORD_W = 48;
	localparam int SAMPLE_W = 16;
	localparam int WORD_BYTES = 6;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] SYNC_CONTROL_ADDR = 12'h300;
	localparam logic [ADDR_W-1:0] CHANNEL0_CONTROL_ADDR = 12'h310;
	// Tuning word window: base + word index * 8 + byte index (0..5)
	localparam logic [ADDR_W-1:0] TUNING_BASE_ADDR = 12'h320;
	localparam logic [6:0] TUNING_BASE_PAGE = 7'h19;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int SYNC_UPDATE_MODE_BIT = 7;
	localparam int SYNC_SOFT_RESET_BIT = 4;
	localparam int SYNC_NEXT_BIT = 1;
	localparam int SYNC_ENABLE_BIT = 0;
	localparam int CH_GAIN_BIT = 6;
	localparam int CH_IF_MODE_LSB = 4;
	localparam logic [DATA_W-1:0] SYNC_CONTROL_RESET = 8'h00;
	localparam logic [DATA_W-1:0] CHANNEL0_CONTROL_RESET = 8'h00;
	localparam logic [DATA_W-1:0] SYNC_CONTROL_MASK = 8'h93;
	localparam logic [DATA_W-1:0] CHANNEL0_CONTROL_MASK = 8'h70;
	localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;
	localparam logic [WORD_W-1:0] WORD_RESET = 48'h000000000000;
	localparam logic [SAMPLE_W-1:0] SAMPLE_ZERO = 16'h0000;
	localparam logic [SAMPLE_W-1:0] SAMPLE_MAX = 16'h7FFF;
	localparam logic [SAMPLE_W-1:0] SAMPLE_MIN = 16'h8000;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		IF_VARIABLE = 2'h0,
		IF_ZERO_HZ = 2'h1,
		IF_SAMPLE_RATE = 2'h2,
		IF_TEST = 2'h3
	} if_mode_t;

	typedef enum logic [1:0] {
		SYNC_OFF = 2'h0,
		SYNC_ONE_SHOT = 2'h1,
		SYNC_CONTINUOUS = 2'h3
	} sync_state_t;

	typedef enum logic [1:0] {
		WORD_FREQUENCY = 2'h0,
		WORD_PHASE = 2'h1,
		WORD_MODULUS_A = 2'h2,
		WORD_MODULUS_B = 2'h3
	} word_sel_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic [WORD_W-1:0] frequency_tuning_word;
		logic [WORD_W-1:0] phase_offset_word;
		logic [WORD_W-1:0] modulus_a_word;
		logic [WORD_W-1:0] modulus_b_word;
	} tuning_set_t;

	// ----------------------------------------------------------------
	// Byte access helpers
	// ----------------------------------------------------------------
	function automatic logic [WORD_W-1:0] put_byte(input logic [WORD_W-1:0] word,
		input logic [2:0] idx, input logic [DATA_W-1:0] data);
		logic [WORD_W-1:0] res;
		res = word;
		res[idx*DATA_W +: DATA_W] = data;
		return res;
	endfunction

	function automatic logic [DATA_W-1:0] get_byte(input logic [WORD_W-1:0] word,
		input logic [2:0] idx);
		return word[idx*DATA_W +: DATA_W];
	endfunction

endpackage

`default_nettype wire

// ### sysref_edge_sync.sv
`default_nettype none

module sysref_edge_sync (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic sysref_pin,
	output logic rise
);

	logic meta_q;
	logic sync_q;
	logic last_q;

	// ----------------------------------------------------------------
	// Two-stage synchroniser, then rising edge detect
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			last_q <= 1'b0;
		end else begin
			meta_q <= sysref_pin;
			sync_q <= meta_q;
			last_q <= sync_q;
		end
	end

	assign rise = sync_q & ~last_q;

endmodule

`default_nettype wire

// ### tuning_word_stage.sv
`default_nettype none

module tuning_word_stage (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic wr_en,
	input wire logic [1:0] word_sel,
	input wire logic [2:0] byte_sel,
	input wire logic [7:0] wdata,
	input wire logic hold_mode,
	input wire logic transfer,
	output ddc_ctrl_pkg::tuning_set_t pending,
	output ddc_ctrl_pkg::tuning_set_t active
);

	ddc_ctrl_pkg::tuning_set_t pending_q;
	ddc_ctrl_pkg::tuning_set_t pending_d;
	ddc_ctrl_pkg::tuning_set_t active_q;
	logic apply;

	// ----------------------------------------------------------------
	// Byte write into the pending words
	// ----------------------------------------------------------------
	always_comb begin
		pending_d = pending_q;
		if (wr_en) begin
			unique case (ddc_ctrl_pkg::word_sel_t'(word_sel))
				ddc_ctrl_pkg::WORD_FREQUENCY: pending_d.frequency_tuning_word =
					ddc_ctrl_pkg::put_byte(pending_q.frequency_tuning_word, byte_sel, wdata);
				ddc_ctrl_pkg::WORD_PHASE: pending_d.phase_offset_word =
					ddc_ctrl_pkg::put_byte(pending_q.phase_offset_word, byte_sel, wdata);
				ddc_ctrl_pkg::WORD_MODULUS_A: pending_d.modulus_a_word =
					ddc_ctrl_pkg::put_byte(pending_q.modulus_a_word, byte_sel, wdata);
				ddc_ctrl_pkg::WORD_MODULUS_B: pending_d.modulus_b_word =
					ddc_ctrl_pkg::put_byte(pending_q.modulus_b_word, byte_sel, wdata);
			endcase
		end
	end

	// Immediate mode follows every write; held mode waits for transfer
	assign apply = ~hold_mode | transfer; // R1 R2

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			pending_q <= '0;
			active_q <= '0;
		end else begin
			pending_q <= pending_d;
			if (apply) begin
				active_q <= pending_d; // R1 R2
			end
		end
	end

	assign pending = pending_q;
	assign active = active_q;

endmodule

`default_nettype wire

// ### downconverter_sync_and_channel_control.sv
//
// Overview of operation
// R1 - Update mode 0 applies words at once
// R2 - Update mode 1 applies words on transfer
// R3 - Soft reset holds channels for alignment
// R4 - No oscillator sync unless enabled and reference on
// R5 - One-shot sync: next edge, then clear enable
// R6 - Continuous sync needs reference at integer multiple
// R7 - Gain bit doubles channel output
// R8 - IF mode field selects four modes
// R9 - Reserved bits read zero, ignore writes
//
`default_nettype none

module downconverter_sync_and_channel_control (
	input wire logic clock,
	input wire logic sys_rst,
	input wire ddc_ctrl_pkg::reg_req_t reg_req,
	output logic [7:0] reg_rdata,
	input wire logic chip_transfer,
	input wire logic sysref_enable,
	input wire logic sysref_pin,
	input wire logic [15:0] sample_in,
	output logic [15:0] sample_out,
	output ddc_ctrl_pkg::tuning_set_t tuning_active,
	output logic channel_reset,
	output logic nco_sync,
	output logic gain_double,
	output ddc_ctrl_pkg::if_mode_t if_mode
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic update_mode_q;
	logic soft_reset_q;
	logic next_sync_q;
	ddc_ctrl_pkg::sync_state_t sync_q;
	ddc_ctrl_pkg::sync_state_t sync_d;
	logic gain_q;
	ddc_ctrl_pkg::if_mode_t if_mode_q;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic nco_sync_q;
	logic channel_reset_q;
	logic [15:0] sample_q;
	logic [15:0] sample_d;
	ddc_ctrl_pkg::tuning_set_t pending;
	ddc_ctrl_pkg::tuning_set_t active;
	logic sysref_rise;

	wire sel_sync = reg_req.addr == ddc_ctrl_pkg::SYNC_CONTROL_ADDR;
	wire sel_ch0 = reg_req.addr == ddc_ctrl_pkg::CHANNEL0_CONTROL_ADDR;
	wire in_page = reg_req.addr[11:5] == ddc_ctrl_pkg::TUNING_BASE_PAGE;
	wire [1:0] word_sel = reg_req.addr[4:3];
	wire [2:0] byte_sel = reg_req.addr[2:0];
	wire byte_ok = byte_sel < 3'h6;
	wire sel_tuning = in_page & byte_ok;
	wire wr_sync = reg_req.wr & sel_sync;
	wire wr_ch0 = reg_req.wr & sel_ch0;
	wire wr_tuning = reg_req.wr & sel_tuning;
	wire sync_en = sync_q != ddc_ctrl_pkg::SYNC_OFF;
	wire sync_armed = sync_en & sysref_enable; // R4
	wire sync_hit = sync_armed & sysref_rise; // R4
	wire [7:0] wmask_sync = reg_req.wdata & ddc_ctrl_pkg::SYNC_CONTROL_MASK; // R9
	wire [7:0] wmask_ch0 = reg_req.wdata & ddc_ctrl_pkg::CHANNEL0_CONTROL_MASK; // R9

	// ----------------------------------------------------------------
	// Saturating doubling of a signed sample
	// ----------------------------------------------------------------
	function automatic logic [15:0] double_sat(input logic [15:0] s);
		logic [16:0] wide;
		wide = {s, 1'b0};
		if (s[15] != s[14]) begin
			return s[15] ? ddc_ctrl_pkg::SAMPLE_MIN : ddc_ctrl_pkg::SAMPLE_MAX;
		end
		return wide[15:0];
	endfunction

	// ----------------------------------------------------------------
	// Reference edge capture
	// ----------------------------------------------------------------
	sysref_edge_sync u_sysref (
		.clock(clock),
		.sys_rst(sys_rst),
		.sysref_pin(sysref_pin),
		.rise(sysref_rise)
	);

	// ----------------------------------------------------------------
	// Tuning words: pending and active copies
	// ----------------------------------------------------------------
	tuning_word_stage u_stage (
		.clock(clock),
		.sys_rst(sys_rst),
		.wr_en(wr_tuning),
		.word_sel(word_sel),
		.byte_sel(byte_sel),
		.wdata(reg_req.wdata),
		.hold_mode(update_mode_q), // R1 R2
		.transfer(chip_transfer), // R2
		.pending(pending),
		.active(active)
	);

	// ----------------------------------------------------------------
	// Synchronisation state
	// ----------------------------------------------------------------
	always_comb begin
		sync_d = sync_q;
		unique case (sync_q)
			ddc_ctrl_pkg::SYNC_OFF: sync_d = ddc_ctrl_pkg::SYNC_OFF;
			ddc_ctrl_pkg::SYNC_ONE_SHOT: begin
				if (sync_hit) begin
					sync_d = ddc_ctrl_pkg::SYNC_OFF; // R5
				end
			end
			ddc_ctrl_pkg::SYNC_CONTINUOUS: sync_d = ddc_ctrl_pkg::SYNC_CONTINUOUS; // R6
			default: sync_d = ddc_ctrl_pkg::SYNC_OFF;
		endcase
		// A software write in the same cycle wins over the self-clear
		if (wr_sync) begin
			if (!wmask_sync[ddc_ctrl_pkg::SYNC_ENABLE_BIT]) begin
				sync_d = ddc_ctrl_pkg::SYNC_OFF; // R4
			end else if (wmask_sync[ddc_ctrl_pkg::SYNC_NEXT_BIT]) begin
				sync_d = ddc_ctrl_pkg::SYNC_ONE_SHOT; // R5
			end else begin
				sync_d = ddc_ctrl_pkg::SYNC_CONTINUOUS; // R6
			end
		end
	end

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			update_mode_q <= 1'b0;
			soft_reset_q <= 1'b0;
			next_sync_q <= 1'b0;
		end else if (wr_sync) begin
			update_mode_q <= wmask_sync[ddc_ctrl_pkg::SYNC_UPDATE_MODE_BIT]; // R1 R2
			soft_reset_q <= wmask_sync[ddc_ctrl_pkg::SYNC_SOFT_RESET_BIT]; // R3
			next_sync_q <= wmask_sync[ddc_ctrl_pkg::SYNC_NEXT_BIT]; // R5
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			sync_q <= ddc_ctrl_pkg::SYNC_OFF;
		end else begin
			sync_q <= sync_d;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			gain_q <= 1'b0;
			if_mode_q <= ddc_ctrl_pkg::IF_VARIABLE;
		end else if (wr_ch0) begin
			gain_q <= wmask_ch0[ddc_ctrl_pkg::CH_GAIN_BIT]; // R7
			if_mode_q <= ddc_ctrl_pkg::if_mode_t'(wmask_ch0[ddc_ctrl_pkg::CH_IF_MODE_LSB +: 2]); // R8
		end
	end

	// ----------------------------------------------------------------
	// Read data, one cycle after the strobe
	// ----------------------------------------------------------------
	always_comb begin
		rdata_d = ddc_ctrl_pkg::READ_ZERO;
		if (reg_req.rd) begin
			if (sel_sync) begin
				rdata_d[ddc_ctrl_pkg::SYNC_UPDATE_MODE_BIT] = update_mode_q;
				rdata_d[ddc_ctrl_pkg::SYNC_SOFT_RESET_BIT] = soft_reset_q;
				rdata_d[ddc_ctrl_pkg::SYNC_NEXT_BIT] = next_sync_q;
				rdata_d[ddc_ctrl_pkg::SYNC_ENABLE_BIT] = sync_en; // R5
			end else if (sel_ch0) begin
				rdata_d[ddc_ctrl_pkg::CH_GAIN_BIT] = gain_q;
				rdata_d[ddc_ctrl_pkg::CH_IF_MODE_LSB +: 2] = if_mode_q;
			end else if (sel_tuning) begin
				unique case (ddc_ctrl_pkg::word_sel_t'(word_sel))
					ddc_ctrl_pkg::WORD_FREQUENCY: rdata_d =
						ddc_ctrl_pkg::get_byte(pending.frequency_tuning_word, byte_sel);
					ddc_ctrl_pkg::WORD_PHASE: rdata_d =
						ddc_ctrl_pkg::get_byte(pending.phase_offset_word, byte_sel);
					ddc_ctrl_pkg::WORD_MODULUS_A: rdata_d =
						ddc_ctrl_pkg::get_byte(pending.modulus_a_word, byte_sel);
					ddc_ctrl_pkg::WORD_MODULUS_B: rdata_d =
						ddc_ctrl_pkg::get_byte(pending.modulus_b_word, byte_sel);
				endcase
			end
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			rdata_q <= ddc_ctrl_pkg::READ_ZERO;
		end else begin
			rdata_q <= rdata_d; // R9
		end
	end

	// ----------------------------------------------------------------
	// Channel outputs
	// ----------------------------------------------------------------
	always_comb begin
		sample_d = sample_in;
		if (channel_reset_q) begin
			sample_d = ddc_ctrl_pkg::SAMPLE_ZERO; // R3
		end else if (gain_q) begin
			sample_d = double_sat(sample_in); // R7
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			nco_sync_q <= 1'b0;
			channel_reset_q <= 1'b0;
			sample_q <= ddc_ctrl_pkg::SAMPLE_ZERO;
		end else begin
			nco_sync_q <= sync_hit; // R4 R5
			channel_reset_q <= soft_reset_q; // R3
			sample_q <= sample_d;
		end
	end

	assign reg_rdata = rdata_q;
	assign sample_out = sample_q;
	assign tuning_active = active;
	assign channel_reset = channel_reset_q;
	assign nco_sync = nco_sync_q;
	assign gain_double = gain_q;
	assign if_mode = if_mode_q;

endmodule

`default_nettype wire

// ### ddc_ctrl_chk.sv
`default_nettype none

module ddc_ctrl_chk (
	input wire logic clock,
	input wire logic sys_rst,
	input wire ddc_ctrl_pkg::reg_req_t reg_req,
	input wire logic [7:0] reg_rdata,
	input wire logic chip_transfer,
	input wire logic sysref_enable,
	input wire logic [15:0] sample_in,
	input wire logic [15:0] sample_out,
	input wire ddc_ctrl_pkg::tuning_set_t tuning_active,
	input wire logic channel_reset,
	input wire logic nco_sync,
	input wire logic gain_double
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);

	function automatic logic [15:0] sat2(input logic [15:0] s);
		if (s[15] != s[14]) begin
			return s[15] ? ddc_ctrl_pkg::SAMPLE_MIN : ddc_ctrl_pkg::SAMPLE_MAX;
		end
		return {s[14:0], 1'h0};
	endfunction

	sequence s_rd(a);
		reg_req.rd && reg_req.addr == a;
	endsequence
	sequence s_soft(v);
		reg_req.wr && reg_req.addr == ddc_ctrl_pkg::SYNC_CONTROL_ADDR && reg_req.wdata[4] == v;
	endsequence
	sequence s_quiet;
		!channel_reset && !$past(channel_reset);
	endsequence

	property p_rd_idle;
		!reg_req.rd |=> reg_rdata == 8'h00;
	endproperty
	property p_rsv_sync;
		s_rd(ddc_ctrl_pkg::SYNC_CONTROL_ADDR) |=> (reg_rdata & 8'h6C) == 8'h00;
	endproperty
	property p_rsv_ch;
		s_rd(ddc_ctrl_pkg::CHANNEL0_CONTROL_ADDR) |=> (reg_rdata & 8'h8F) == 8'h00;
	endproperty
	property p_unmapped;
		s_rd(12'h326) |=> reg_rdata == 8'h00;
	endproperty
	property p_soft_on;
		s_soft(1'h1) |-> ##[1:2] channel_reset;
	endproperty
	property p_soft_off;
		s_soft(1'h0) |-> ##[1:2] !channel_reset;
	endproperty
	property p_hold_zero;
		channel_reset && $past(channel_reset) |-> sample_out == 16'h0000;
	endproperty
	property p_gain;
		s_quiet and (gain_double && $past(gain_double)) |-> sample_out == sat2($past(sample_in));
	endproperty
	property p_pulse;
		nco_sync |=> !nco_sync;
	endproperty
	property p_sync_en;
		nco_sync |-> $past(sysref_enable);
	endproperty
	property p_tuning;
		$changed(tuning_active) |-> $past(reg_req.wr) || $past(reg_req.wr, 2) || $past(chip_transfer);
	endproperty

	a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
	a_rsv_sync: assert property (p_rsv_sync) else $error("sync reserved bit set");
	a_rsv_ch: assert property (p_rsv_ch) else $error("channel reserved bit set");
	a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
	a_soft_on: assert property (p_soft_on) else $error("channel reset not raised");
	a_soft_off: assert property (p_soft_off) else $error("channel reset not cleared");
	a_hold_zero: assert property (p_hold_zero) else $error("sample out during reset");
	a_gain: assert property (p_gain) else $error("sample not doubled");
	a_pulse: assert property (p_pulse) else $error("sync pulse too long");
	a_sync_en: assert property (p_sync_en) else $error("sync with reference off");
	a_tuning: assert property (p_tuning) else $error("tuning changed unprompted");
endmodule

`default_nettype wire

// ### test_downconverter_sync_and_channel_control.sv
`default_nettype none

module test_downconverter_sync_and_channel_control;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock, sys_rst, chip_transfer, sysref_enable, sysref_pin;
	ddc_ctrl_pkg::reg_req_t reg_req;
	logic [7:0] reg_rdata;
	logic [15:0] sample_in, sample_out;
	ddc_ctrl_pkg::tuning_set_t tuning_active;
	logic channel_reset, nco_sync, gain_double;
	ddc_ctrl_pkg::if_mode_t if_mode;
	int mismatches, compares, syncs, base;
	logic [7:0] row_in [6] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'hFF, 8'h8F};
	logic [7:0] row_out [6] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'h70, 8'h00};
	logic [7:0] sc_ctl [4] = '{8'h00, 8'h01, 8'h03, 8'h01};
	logic [7:0] sc_en [4] = '{8'h01, 8'h00, 8'h01, 8'h01};
	logic [7:0] sc_n [4] = '{8'h00, 8'h00, 8'h01, 8'h02};
	logic [7:0] sc_rb [4] = '{8'h00, 8'h01, 8'h02, 8'h01};

	downconverter_sync_and_channel_control downconverter_sync_and_channel_control_i (
		.clock(clock), .sys_rst(sys_rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
		.chip_transfer(chip_transfer), .sysref_enable(sysref_enable),
		.sysref_pin(sysref_pin), .sample_in(sample_in), .sample_out(sample_out),
		.tuning_active(tuning_active), .channel_reset(channel_reset),
		.nco_sync(nco_sync), .gain_double(gain_double), .if_mode(if_mode)
	);

	initial begin
		clock = 1'h0;
		forever #10 clock = ~clock;
	end

	always @(posedge clock) begin
		sample_in <= sample_in + 16'h1357;
		if (nco_sync === 1'h1) begin
			syncs <= syncs + 1;
		end
	end

	task automatic check8(input logic [7:0] g, input logic [7:0] e);
		compares++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic check48(input logic [47:0] g, input logic [47:0] e);
		compares++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_req <= '{wr: 1'h1, rd: 1'h0, addr: a, wdata: d};
		@(posedge clock);
		reg_req.wr <= 1'h0;
	endtask

	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		@(posedge clock);
		reg_req <= '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 8'h00};
		@(posedge clock);
		reg_req.rd <= 1'h0;
		#1 check8(reg_rdata, e);
	endtask

	task automatic settle();
		repeat (2) @(posedge clock);
		#1;
	endtask

	// Reference pulse long enough on both levels to pass the synchroniser
	task automatic pulse();
		@(posedge clock);
		sysref_pin <= 1'h1;
		repeat (3) @(posedge clock);
		sysref_pin <= 1'h0;
		repeat (6) @(posedge clock);
	endtask

	task automatic conclude();
		if (mismatches == 0 && compares > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	initial begin
		repeat (4000) @(posedge clock);
		mismatches++;
		conclude();
	end

	initial begin
		sys_rst = 1'h1;
		reg_req = '0;
		chip_transfer = 1'h0;
		sysref_enable = 1'h0;
		sysref_pin = 1'h0;
		sample_in = 16'h0123;
		mismatches = 0;
		compares = 0;
		syncs = 0;
		repeat (10) @(posedge clock);
		sys_rst <= 1'h0;
		#1 check8({3'h0, channel_reset, nco_sync, gain_double, if_mode}, 8'h00);
		rd(ddc_ctrl_pkg::SYNC_CONTROL_ADDR, 8'h00);
		for (int i = 0; i < 6; i++) begin
			wr(ddc_ctrl_pkg::CHANNEL0_CONTROL_ADDR, row_in[i]);
			rd(ddc_ctrl_pkg::CHANNEL0_CONTROL_ADDR, row_out[i]);
			check8({7'h00, gain_double}, {7'h00, row_out[i][6]});
			check8({6'h00, if_mode}, {6'h00, row_out[i][5:4]});
		end
		wr(ddc_ctrl_pkg::CHANNEL0_CONTROL_ADDR, 8'h40);
		wr(ddc_ctrl_pkg::SYNC_CONTROL_ADDR, 8'hFF);
		rd(ddc_ctrl_pkg::SYNC_CONTROL_ADDR, 8'h93);
		check8({7'h00, channel_reset}, 8'h01);
		settle();
		check8(sample_out[7:0], 8'h00);
		wr(ddc_ctrl_pkg::SYNC_CONTROL_ADDR, 8'h00);
		settle();
		check8({7'h00, channel_reset}, 8'h00);
		wr(12'h320, 8'hA5);
		settle();
		check48(tuning_active.frequency_tuning_word, 48'h0000000000A5);
		rd(12'h320, 8'hA5);
		wr(ddc_ctrl_pkg::SYNC_CONTROL_ADDR, 8'h80);
		wr(12'h328, 8'h3C);
		wr(12'h33D, 8'h5A);
		settle();
		check48(tuning_active.phase_offset_word, 48'h000000000000);
		@(posedge clock);
		chip_transfer <= 1'h1;
		@(posedge clock);
		chip_transfer <= 1'h0;
		settle();
		check48(tuning_active.phase_offset_word, 48'h00000000003C);
		check48(tuning_active.modulus_b_word, 48'h5A0000000000);
		rd(12'h326, 8'h00);
		rd(12'h400, 8'h00);
		for (int i = 0; i < 4; i++) begin
			wr(ddc_ctrl_pkg::SYNC_CONTROL_ADDR, sc_ctl[i]);
			sysref_enable <= sc_en[i][0];
			settle();
			base = syncs;
			pulse();
			pulse();
			#1 check8(8'(syncs - base), sc_n[i]);
			rd(ddc_ctrl_pkg::SYNC_CONTROL_ADDR, sc_rb[i]);
		end
		conclude();
	end
endmodule

bind downconverter_sync_and_channel_control ddc_ctrl_chk ddc_ctrl_chk_i (
	.clock(clock), .sys_rst(sys_rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
	.chip_transfer(chip_transfer), .sysref_enable(sysref_enable),
	.sample_in(sample_in), .sample_out(sample_out), .tuning_active(tuning_active),
	.channel_reset(channel_reset), .nco_sync(nco_sync), .gain_double(gain_double)
);

`default_nettype wire
